// [sfcd_map.svh]
// constants for the single-precision classify and denormalize datapath
// assumes it is included by bare name from the package and the design files
`ifndef SFCD_MAP_SVH
`define SFCD_MAP_SVH

// -----------------------------------------------------------------
// word layout
// -----------------------------------------------------------------
`define SFCD_SIGN_BIT   31
`define SFCD_EXP_HI     30
`define SFCD_EXP_LO     23
`define SFCD_FRAC_HI    22
`define SFCD_QUIET_BIT  22
`define SFCD_SIG_BITS   5'h18

// -----------------------------------------------------------------
// exponent constants
// -----------------------------------------------------------------
`define SFCD_EXP_ZERO   8'h00
`define SFCD_EXP_MAX    8'hFF
`define SFCD_BIAS8      8'h7F
`define SFCD_BIAS12     12'sh07F
`define SFCD_EXP_MIN    (-12'sh07E)
`define SFCD_EXP_TOP    12'sh07F
`define SFCD_INDEF      32'hFFC00000

// -----------------------------------------------------------------
// rounding mode code that yields a negative exact zero
// -----------------------------------------------------------------
`define SFCD_RND_DOWN   2'h1

`endif

// [sfcd_pkg.sv]
// types shared by the classify and denormalize datapath
// assumes sfcd_map.svh is on the include path
`include "sfcd_map.svh"

package sfcd_pkg;

    // operand and result classes
    typedef enum logic [2:0] {
        sfcd_zero,
        sfcd_denormal,
        sfcd_normal,
        sfcd_infinity,
        sfcd_quiet_not_a_number,
        sfcd_signaling_not_a_number,
        sfcd_indefinite
    } sfcd_class_e;

    // all registered state of the top module
    typedef struct packed {
        logic              op_out_valid;
        sfcd_class_e       a_class;
        sfcd_class_e       b_class;
        logic              a_negative;
        logic              b_negative;
        logic signed [9:0] a_exp;
        logic signed [9:0] b_exp;
        logic [23:0]       a_sig;
        logic [23:0]       b_sig;
        logic              denormal_operand;
        logic              operands_equal;
        logic              res_out_valid;
        logic [31:0]       res_word;
        sfcd_class_e       res_class;
        logic              underflow;
    } sfcd_state_s;

endpackage : sfcd_pkg

// [sfcd_lzc.sv]
// leading zero counter for a 24-bit significand
// assumes a purely combinational use inside the result path
`timescale 1ns/1ns
`include "sfcd_map.svh"

module sfcd_lzc (
    input  wire logic [23:0] sig,   // significand, integer bit at the top
    output logic      [4:0]  count  // leading zeros, 24 when all zero
);
    import sfcd_pkg::*;

    // -----------------------------------------------------------------
    // scan from the bottom so the topmost one wins
    // -----------------------------------------------------------------
    always_comb begin
        count = `SFCD_SIG_BITS;
        for (int i = 0; i < 24; i++) begin
            if (sig[i]) begin
                count = 5'(23 - i);
            end
        end
    end

endmodule : sfcd_lzc

// [sfcd_datapath.sv]
// single-precision operand classifier and result normalizer
// assumes operands and raw results arrive synchronous to ref_clk
// assumes the pipeline around it consumes outputs one cycle later
`timescale 1ns/1ns
`include "sfcd_map.svh"

module sfcd_datapath (
    input  wire logic                      ref_clk,          // core clock, 250 MHz
    input  wire logic                      reset,            // synchronous, active high
    // operand side
    input  wire logic                      op_valid,         // operand pair present
    input  wire logic [31:0]               op_a,             // first source word
    input  wire logic [31:0]               op_b,             // second source word
    // raw result side
    input  wire logic                      res_valid,        // raw result present
    input  wire logic                      res_sign,         // sign of the raw result
    input  wire logic signed [9:0]         res_exp,          // true exponent, unbiased
    input  wire logic [23:0]               res_sig,          // integer bit plus fraction
    input  wire logic                      res_cancel,       // exact zero by cancellation
    input  wire logic [1:0]                rnd_mode,         // selected rounding mode
    // decoded operands
    output logic                           op_out_valid,     // decoded pair valid
    output sfcd_pkg::sfcd_class_e          a_class,          // class of first operand
    output sfcd_pkg::sfcd_class_e          b_class,          // class of second operand
    output logic                           a_negative,       // sign of first operand
    output logic                           b_negative,       // sign of second operand
    output logic signed [9:0]              a_exp,            // true exponent of a
    output logic signed [9:0]              b_exp,            // true exponent of b
    output logic [23:0]                    a_sig,            // full significand of a
    output logic [23:0]                    b_sig,            // full significand of b
    output logic                           denormal_operand, // a denormal was supplied
    output logic                           operands_equal,   // a equals b in value
    // packed result
    output logic                           res_out_valid,    // result word valid
    output logic [31:0]                    res_word,         // encoded result
    output sfcd_pkg::sfcd_class_e          res_class,        // class of the result
    output logic                           underflow         // tiny result produced
);
    import sfcd_pkg::*;

    // -----------------------------------------------------------------
    // state and intermediates
    // -----------------------------------------------------------------
    sfcd_state_s        state;      // registered copy
    sfcd_state_s        next_state; // combinational copy
    logic [4:0]         lead_zeros; // leading zeros of the raw significand
    logic signed [11:0] wide_exp;   // raw exponent widened for headroom
    logic signed [11:0] room;       // places left above the minimum
    logic [4:0]         shl;        // left shift actually applied
    logic signed [11:0] exp1;       // exponent after normalizing
    logic [23:0]        sig1;       // significand after normalizing
    logic signed [11:0] rsh;        // right shift for gradual underflow
    logic signed [11:0] exp2;       // exponent after denormalizing
    logic [23:0]        sig2;       // significand after denormalizing
    logic signed [11:0] biased;     // exponent with the bias added
    logic               zero_sign;  // sign chosen for an exact zero

    // -----------------------------------------------------------------
    // decode helpers
    // -----------------------------------------------------------------

    // sort one encoding into its class
    function automatic sfcd_class_e sfcd_classify(input logic [31:0] w);
        logic [7:0]  e;
        logic [22:0] f;
        e = w[`SFCD_EXP_HI:`SFCD_EXP_LO];
        f = w[`SFCD_FRAC_HI:0];
        if (e == `SFCD_EXP_ZERO) begin
            // zero exponent splits on the fraction
            if (f == 23'h000000) begin
                sfcd_classify = sfcd_zero;
            end else begin
                sfcd_classify = sfcd_denormal;
            end
        end else if (e == `SFCD_EXP_MAX) begin
            // top exponent holds the non-numbers
            if (f == 23'h000000) begin
                sfcd_classify = sfcd_infinity;
            end else if (w == `SFCD_INDEF) begin
                sfcd_classify = sfcd_indefinite;
            end else if (f[`SFCD_QUIET_BIT]) begin
                sfcd_classify = sfcd_quiet_not_a_number;
            end else begin
                sfcd_classify = sfcd_signaling_not_a_number;
            end
        end else begin
            // biased 1 through 254
            sfcd_classify = sfcd_normal;
        end
    endfunction : sfcd_classify

    // true exponent; denormals sit at the minimum, not at minus bias
    function automatic logic signed [9:0] sfcd_true_exp(input logic [31:0] w);
        logic [7:0] e;
        e = w[`SFCD_EXP_HI:`SFCD_EXP_LO];
        if (e == `SFCD_EXP_ZERO) begin
            sfcd_true_exp = 10'(`SFCD_EXP_MIN);
        end else begin
            sfcd_true_exp = $signed({2'h0, e}) - $signed({2'h0, `SFCD_BIAS8});
        end
    endfunction : sfcd_true_exp

    // full significand with the implied integer bit restored
    function automatic logic [23:0] sfcd_signif(input logic [31:0] w);
        logic j_bit;
        j_bit = (w[`SFCD_EXP_HI:`SFCD_EXP_LO] != `SFCD_EXP_ZERO);
        sfcd_signif = {j_bit, w[`SFCD_FRAC_HI:0]};
    endfunction : sfcd_signif

    // true when the class is a non-number
    function automatic logic sfcd_is_nan(input sfcd_class_e c);
        sfcd_is_nan = (c == sfcd_quiet_not_a_number)
                    || (c == sfcd_signaling_not_a_number)
                    || (c == sfcd_indefinite);
    endfunction : sfcd_is_nan

    // -----------------------------------------------------------------
    // leading zero counter for the result path
    // -----------------------------------------------------------------
    sfcd_lzc u_lzc (
        .sig   (res_sig),
        .count (lead_zeros)
    );

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    // one stage: both paths settle within a single 4 ns period,
    // traded for latency since the shifters are only 24 bits wide
    always_comb begin
        next_state = state;
        wide_exp   = {{2{res_exp[9]}}, res_exp};
        room       = wide_exp - `SFCD_EXP_MIN;
        shl        = 5'h00;
        exp1       = wide_exp;
        sig1       = res_sig;
        rsh        = 12'sh000;
        exp2       = wide_exp;
        sig2       = res_sig;
        biased     = 12'sh000;
        zero_sign  = res_sign;

        // operand decode, held between valid pairs
        next_state.op_out_valid = op_valid;
        if (op_valid) begin
            next_state.a_class    = sfcd_classify(op_a);
            next_state.b_class    = sfcd_classify(op_b);
            next_state.a_negative = op_a[`SFCD_SIGN_BIT];
            next_state.b_negative = op_b[`SFCD_SIGN_BIT];
            next_state.a_exp      = sfcd_true_exp(op_a);
            next_state.b_exp      = sfcd_true_exp(op_b);
            next_state.a_sig      = sfcd_signif(op_a);
            next_state.b_sig      = sfcd_signif(op_b);
            // either source being tiny is enough
            next_state.denormal_operand =
                (sfcd_classify(op_a) == sfcd_denormal)
                || (sfcd_classify(op_b) == sfcd_denormal);
            // non-numbers never compare equal; signed zeros do
            if (sfcd_is_nan(sfcd_classify(op_a))
                || sfcd_is_nan(sfcd_classify(op_b))) begin
                next_state.operands_equal = 1'b0;
            end else if ((sfcd_classify(op_a) == sfcd_zero)
                         && (sfcd_classify(op_b) == sfcd_zero)) begin
                next_state.operands_equal = 1'b1;
            end else begin
                next_state.operands_equal = (op_a == op_b);
            end
        end else begin
            // exception indications are one-cycle pulses
            next_state.denormal_operand = 1'b0;
        end

        // normalize: spend leading zeros only while above the minimum
        if ($signed({7'h00, lead_zeros}) <= room) begin
            shl = lead_zeros;
        end else if (room > 12'sh000) begin
            shl = room[4:0];
        end else begin
            shl = 5'h00;
        end
        exp1 = wide_exp - $signed({7'h00, shl});
        sig1 = res_sig << shl;

        // gradual underflow: shift right until the minimum is reached
        if (exp1 < `SFCD_EXP_MIN) begin
            rsh  = `SFCD_EXP_MIN - exp1;
            exp2 = `SFCD_EXP_MIN;
            if (rsh >= $signed({7'h00, `SFCD_SIG_BITS})) begin
                sig2 = 24'h000000;
            end else begin
                sig2 = sig1 >> rsh[4:0];
            end
        end else begin
            exp2 = exp1;
            sig2 = sig1;
        end
        biased = exp2 + `SFCD_BIAS12;

        // sign of an exact zero from cancellation follows rounding
        if (res_cancel) begin
            zero_sign = (rnd_mode == `SFCD_RND_DOWN);
        end else begin
            zero_sign = res_sign;
        end

        // pack the result; bits shifted out are dropped, no rounding
        next_state.res_out_valid = res_valid;
        next_state.underflow     = 1'b0;
        if (res_valid) begin
            if (res_sig == 24'h000000) begin
                // exact zero
                next_state.res_word  = {zero_sign, 31'h00000000};
                next_state.res_class = sfcd_zero;
            end else if (sig2 == 24'h000000) begin
                // everything shifted out: tiny result flushed to zero
                next_state.res_word  = {res_sign, 31'h00000000};
                next_state.res_class = sfcd_zero;
                next_state.underflow = 1'b1;
            end else if (exp2 > `SFCD_EXP_TOP) begin
                // beyond the top exponent: saturate to infinity
                next_state.res_word  = {res_sign, `SFCD_EXP_MAX, 23'h000000};
                next_state.res_class = sfcd_infinity;
            end else if (sig2[23]) begin
                // integer bit set: normal encoding
                next_state.res_word  = {res_sign, biased[7:0], sig2[22:0]};
                next_state.res_class = sfcd_normal;
            end else begin
                // could not normalize: denormal encoding
                next_state.res_word  = {res_sign, `SFCD_EXP_ZERO, sig2[22:0]};
                next_state.res_class = sfcd_denormal;
                next_state.underflow = 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    // synchronous reset clears everything to a quiet zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // -----------------------------------------------------------------
    // outputs, each straight from the state register
    // -----------------------------------------------------------------
    assign op_out_valid     = state.op_out_valid;
    assign a_class          = state.a_class;
    assign b_class          = state.b_class;
    assign a_negative       = state.a_negative;
    assign b_negative       = state.b_negative;
    assign a_exp            = state.a_exp;
    assign b_exp            = state.b_exp;
    assign a_sig            = state.a_sig;
    assign b_sig            = state.b_sig;
    assign denormal_operand = state.denormal_operand;
    assign operands_equal   = state.operands_equal;
    assign res_out_valid    = state.res_out_valid;
    assign res_word         = state.res_word;
    assign res_class        = state.res_class;
    assign underflow        = state.underflow;

endmodule : sfcd_datapath

// [sfcd_datapath_props.sv]
// checker for the classify and denormalize datapath ports
// assumes it is bound onto sfcd_datapath from the bench top
`timescale 1ns/1ns

module sfcd_datapath_props (
    input logic                  ref_clk,
    input logic                  reset,
    input logic                  op_valid,
    input logic [31:0]           op_a,
    input logic [31:0]           op_b,
    input logic                  res_valid,
    input logic                  res_sign,
    input logic signed [9:0]     res_exp,
    input logic [23:0]           res_sig,
    input logic                  res_cancel,
    input logic [1:0]            rnd_mode,
    input logic                  op_out_valid,
    input sfcd_pkg::sfcd_class_e a_class,
    input logic                  a_negative,
    input logic signed [9:0]     a_exp,
    input logic [23:0]           a_sig,
    input logic                  denormal_operand,
    input logic                  operands_equal,
    input logic                  res_out_valid,
    input logic [31:0]           res_word,
    input sfcd_pkg::sfcd_class_e res_class,
    input logic                  underflow
);
    import sfcd_pkg::*;
    // ------------------------------------------------------------
    // single domain, so one clock and one reset for every property
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic [7:0] ea    = op_a[30:23];              // biased exponent of a
    wire logic       den_a = (ea == 8'h00) && (op_a[22:0] != 23'h0);
    wire logic       den_b = (op_b[30:23] == 8'h00) && (op_b[22:0] != 23'h0);

    property p_op_lat; op_valid |=> op_out_valid; endproperty
    a_op_lat: assert property (p_op_lat) else $error("decoded pair late");
    property p_den_op; op_valid |=> denormal_operand == $past(den_a || den_b); endproperty
    a_den_op: assert property (p_den_op) else $error("denormal operand flag wrong");
    // the flag is a pulse, a stuck flag would mislead the trap logic
    property p_den_pulse; !op_valid |=> !denormal_operand; endproperty
    a_den_pulse: assert property (p_den_pulse) else $error("denormal flag held");
    property p_norm;
        op_valid && ea != 8'h00 && ea != 8'hFF |=> a_class == sfcd_normal
            && a_exp == $past($signed({2'b00, ea}) - 10'sd127)
            && a_sig == $past({1'b1, op_a[22:0]});
    endproperty
    a_norm: assert property (p_norm) else $error("normal decode wrong");
    property p_denorm;
        op_valid && den_a |=> a_class == sfcd_denormal && a_exp == -10'sd126
            && a_sig == $past({1'b0, op_a[22:0]});
    endproperty
    a_denorm: assert property (p_denorm) else $error("denormal decode wrong");
    property p_zero;
        op_valid && op_a[30:0] == 31'h0 && op_b[30:0] == 31'h0
            |=> a_class == sfcd_zero && operands_equal;
    endproperty
    a_zero: assert property (p_zero) else $error("signed zeros not equal");
    property p_inf;
        op_valid && ea == 8'hFF && op_a[22:0] == 23'h0
            |=> a_class == sfcd_infinity && a_negative == $past(op_a[31]);
    endproperty
    a_inf: assert property (p_inf) else $error("infinity decode wrong");
    property p_nan;
        op_valid && ea == 8'hFF && op_a[22:0] != 23'h0 && op_a != 32'hFFC00000
            |=> a_class == ($past(op_a[22]) ? sfcd_quiet_not_a_number
                                            : sfcd_signaling_not_a_number);
    endproperty
    a_nan: assert property (p_nan) else $error("nan kind wrong");
    property p_hold; !op_valid |=> $stable(a_class) && $stable(a_sig); endproperty
    a_hold: assert property (p_hold) else $error("decoded fields moved");
    property p_res_norm;
        res_valid && res_sig[23] && res_exp >= -10'sd126 && res_exp <= 10'sd127
            |=> res_class == sfcd_normal && !underflow
            && res_word == $past({res_sign, res_exp[7:0] + 8'h7F, res_sig[22:0]});
    endproperty
    a_res_norm: assert property (p_res_norm) else $error("normal result wrong");
    property p_flush;
        res_valid && res_sig[23] && res_exp <= -10'sd150 |=> res_word[30:0] == 31'h0 && underflow;
    endproperty
    a_flush: assert property (p_flush) else $error("flush to zero wrong");
    property p_cancel;
        res_valid && res_cancel && res_sig == 24'h0
            |=> res_word == {$past(rnd_mode) == 2'h1, 31'h0} && !underflow;
    endproperty
    a_cancel: assert property (p_cancel) else $error("zero sign wrong");
    property p_uf; res_out_valid && res_class == sfcd_denormal |-> underflow; endproperty
    a_uf: assert property (p_uf) else $error("underflow missing");
    c_den: cover property (op_valid && den_a);
    c_uf: cover property (res_out_valid && underflow);
    c_inf: cover property (op_out_valid && a_class == sfcd_infinity);
endmodule : sfcd_datapath_props

// [sfcd_pipe_model.sv]
// model of the arithmetic pipeline feeding the datapath
// assumes tasks are called from one process of the bench
`timescale 1ns/1ns

module sfcd_pipe_model (
    input  logic              ref_clk,    // core clock
    output logic              op_valid,   // operand pair present
    output logic [31:0]       op_a,       // first source word
    output logic [31:0]       op_b,       // second source word
    output logic              res_valid,  // raw result present
    output logic              res_sign,   // raw sign
    output logic signed [9:0] res_exp,    // raw true exponent
    output logic [23:0]       res_sig,    // raw significand
    output logic              res_cancel, // exact cancellation
    output logic [1:0]        rnd_mode    // rounding mode
);
    // idle values at time zero
    initial begin
        {op_valid, op_a, op_b, res_valid, res_sign} = '0;
        {res_exp, res_sig, res_cancel, rnd_mode} = '0;
    end

    // one pair for one cycle; released words flip so stale data never matches
    task automatic send_op(input logic [31:0] a, input logic [31:0] b);
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_a     <= a;
        op_b     <= b;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        op_a     <= ~a;
        op_b     <= ~b;
    endtask : send_op

    // one raw result for one cycle; on release exponent and significand flip, sign, cancel and mode hold
    task automatic send_res(input logic s, input logic signed [9:0] e,
                            input logic [23:0] g, input logic c, input logic [1:0] r);
        @(posedge ref_clk);
        res_valid  <= 1'b1;
        res_sign   <= s;
        res_exp    <= e;
        res_sig    <= g;
        res_cancel <= c;
        rnd_mode   <= r;
        @(posedge ref_clk);
        res_valid  <= 1'b0;
        res_exp    <= ~e;
        res_sig    <= ~g;
    endtask : send_res
endmodule : sfcd_pipe_model

// [sfcd_datapath_tb_top.sv]
// self-checking bench for the classify and denormalize datapath
// assumes sfcd_pkg, the design and the pipe model are compiled first
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module sfcd_datapath_tb_top;
    import sfcd_pkg::*;
    logic ref_clk, reset, op_valid, res_valid, res_sign, res_cancel;
    logic [31:0] op_a, op_b, res_word;
    logic signed [9:0] res_exp, a_exp, b_exp;
    logic [23:0] res_sig, a_sig, b_sig;
    logic [1:0] rnd_mode;
    logic op_out_valid, a_negative, b_negative, denormal_operand;
    logic operands_equal, res_out_valid, underflow;
    sfcd_class_e a_class, b_class, res_class;
    int miscompares = 0;
    int checked = 0;
    // ------------------------------------------------------------
    // stimulus tables: operand words and raw results
    // ------------------------------------------------------------
    typedef struct {logic [31:0] a, b; sfcd_class_e c; logic signed [9:0] e;
                    logic [23:0] s; logic d, q;} sfcd_op_row_s;
    typedef struct {logic sg; logic signed [9:0] e; logic [23:0] s; logic cn;
                    logic [1:0] rm; logic [31:0] w; sfcd_class_e c; logic u;} sfcd_res_row_s;
    sfcd_op_row_s ops [10] = '{
        '{32'h80000000, 32'h00000000, sfcd_zero, -10'sd126, 24'h000000, 1'b0, 1'b1},
        '{32'h43322000, 32'h43322000, sfcd_normal, 10'sd7, 24'hB22000, 1'b0, 1'b1},
        '{32'h00000001, 32'h3F800000, sfcd_denormal, -10'sd126, 24'h000001, 1'b1, 1'b0},
        '{32'h00800000, 32'h00800000, sfcd_normal, -10'sd126, 24'h800000, 1'b0, 1'b1},
        '{32'h7F7FFFFF, 32'h00000000, sfcd_normal, 10'sd127, 24'hFFFFFF, 1'b0, 1'b0},
        '{32'hFF800000, 32'h7F800000, sfcd_infinity, 10'sd0, 24'h0, 1'b0, 1'b0},
        '{32'h7FC00001, 32'h7FC00001, sfcd_quiet_not_a_number, 10'sd0, 24'h0, 1'b0, 1'b0},
        '{32'h7F800001, 32'h3F800000, sfcd_signaling_not_a_number, 10'sd0, 24'h0, 1'b0, 1'b0},
        '{32'hFFC00000, 32'h00000000, sfcd_indefinite, 10'sd0, 24'h0, 1'b0, 1'b0},
        '{32'h3F800000, 32'h807FFFFF, sfcd_normal, 10'sd0, 24'h800000, 1'b1, 1'b0}};
    // cancellation rows walk every rounding mode; only round down gives -0
    sfcd_res_row_s rss [11] = '{
        '{1'b0, -10'sd129, 24'hAE0000, 1'b0, 2'h0, 32'h0015C000, sfcd_denormal, 1'b1},
        '{1'b0, 10'sd3, 24'h0B2200, 1'b0, 2'h0, 32'h3F322000, sfcd_normal, 1'b0},
        '{1'b0, -10'sd125, 24'h200000, 1'b0, 2'h0, 32'h00400000, sfcd_denormal, 1'b1},
        '{1'b0, -10'sd160, 24'h800000, 1'b0, 2'h0, 32'h00000000, sfcd_zero, 1'b1},
        '{1'b1, 10'sd0, 24'h000000, 1'b1, 2'h0, 32'h00000000, sfcd_zero, 1'b0},
        '{1'b0, 10'sd0, 24'h000000, 1'b1, 2'h1, 32'h80000000, sfcd_zero, 1'b0},
        '{1'b1, 10'sd0, 24'h000000, 1'b1, 2'h2, 32'h00000000, sfcd_zero, 1'b0},
        '{1'b1, 10'sd0, 24'h000000, 1'b1, 2'h3, 32'h00000000, sfcd_zero, 1'b0},
        '{1'b1, 10'sd127, 24'hFFFFFF, 1'b0, 2'h0, 32'hFF7FFFFF, sfcd_normal, 1'b0},
        '{1'b0, -10'sd126, 24'h800000, 1'b0, 2'h0, 32'h00800000, sfcd_normal, 1'b0},
        '{1'b0, 10'sd128, 24'h800000, 1'b0, 2'h0, 32'h7F800000, sfcd_infinity, 1'b0}};

    sfcd_datapath sfcd_datapath_inst (.ref_clk, .reset, .op_valid, .op_a, .op_b,
        .res_valid, .res_sign, .res_exp, .res_sig, .res_cancel, .rnd_mode,
        .op_out_valid, .a_class, .b_class, .a_negative, .b_negative, .a_exp, .b_exp,
        .a_sig, .b_sig, .denormal_operand, .operands_equal, .res_out_valid,
        .res_word, .res_class, .underflow);
    sfcd_pipe_model sfcd_pipe_model_inst (.ref_clk, .op_valid, .op_a, .op_b,
        .res_valid, .res_sign, .res_exp, .res_sig, .res_cancel, .rnd_mode);

    // counts, verdict and the one exit of the run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // about 55 cycles are needed; this cuts a hang far beyond that
    initial begin
        #20000;
        miscompares++;
        give_verdict();
    end

    initial begin
        reset = 1'b1;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK("a_class", sfcd_zero, a_class)
        `CHK("res_word", 32'h0, res_word)
        // operand path: every class, both operands, boundaries of the range
        for (int i = 0; i < 10; i++) begin
            sfcd_pipe_model_inst.send_op(ops[i].a, ops[i].b);
            #1;
            `CHK("op_out_valid", 1'b1, op_out_valid)
            `CHK("a_class", ops[i].c, a_class)
            `CHK("a_negative", ops[i].a[31], a_negative)
            `CHK("b_negative", ops[i].b[31], b_negative)
            `CHK("denormal_operand", ops[i].d, denormal_operand)
            `CHK("operands_equal", ops[i].q, operands_equal)
            if (ops[i].a[30:0] == ops[i].b[30:0]) begin
                `CHK("b_class", ops[i].c, b_class)
            end
            if (ops[i].c inside {sfcd_zero, sfcd_denormal, sfcd_normal}) begin
                `CHK("a_exp", ops[i].e, a_exp)
                `CHK("a_sig", ops[i].s, a_sig)
                if (ops[i].a[30:0] == ops[i].b[30:0]) begin
                    `CHK("b_exp", ops[i].e, b_exp)
                    `CHK("b_sig", ops[i].s, b_sig)
                end
            end
        end
        // result path: normalize, gradual underflow, flush, signed zero
        for (int i = 0; i < 11; i++) begin
            sfcd_pipe_model_inst.send_res(rss[i].sg, rss[i].e, rss[i].s, rss[i].cn, rss[i].rm);
            #1;
            `CHK("res_out_valid", 1'b1, res_out_valid)
            `CHK("res_word", rss[i].w, res_word)
            `CHK("res_class", rss[i].c, res_class)
            `CHK("underflow", rss[i].u, underflow)
        end
        give_verdict();
    end
endmodule : sfcd_datapath_tb_top

bind sfcd_datapath sfcd_datapath_props sfcd_datapath_props_inst (.ref_clk, .reset,
    .op_valid, .op_a, .op_b, .res_valid, .res_sign, .res_exp, .res_sig, .res_cancel,
    .rnd_mode, .op_out_valid, .a_class, .a_negative, .a_exp, .a_sig, .denormal_operand,
    .operands_equal, .res_out_valid, .res_word, .res_class, .underflow);
